// ===== design/spo_defines.svh
`ifndef SPO_DEFINES_SVH
`define SPO_DEFINES_SVH
// ==================================================
// register indices; byte address is four times the index
`define SPO_IDX_PAT_CTRL    8'h34
`define SPO_IDX_TEST_SCAN   8'h3D
// register byte addresses
`define SPO_ADDR_PAT_CTRL   8'hD0
`define SPO_ADDR_TEST_SCAN  8'hF4
`define SPO_ADDR_VAL_UP     8'h40
`define SPO_ADDR_VAL_LO     8'h44
`define SPO_ADDR_STEP       8'h48
`define SPO_ADDR_PITCH      8'h4C
`define SPO_ADDR_START      8'h50
`define SPO_ADDR_WIDTH      8'h54
`define SPO_ADDR_OUT_CFG    8'h58
`define SPO_ADDR_STATUS     8'h5C
// ==================================================
// field positions
`define SPO_PC_ENABLE       0
`define SPO_PC_SEL_LO       4
`define SPO_TS_TEST_MODE    1
`define SPO_CFG_QUAD        0
`define SPO_CFG_CORR        1
`define SPO_CFG_PAT_SEL     2
// ==================================================
// reset values and timing
`define SPO_RST_BYTE        8'h00
`define SPO_SLOT_BITS       16
`define SPO_WORD_BITS       14
`define SPO_BIT_CYCLES      1
`endif

// ===== design/spo_pattern_gen.sv
`timescale 1ns/1ns
`include "spo_defines.svh"
// ==================================================
// test pattern source, advanced once per pixel
module spo_pattern_gen (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              run,
    input  wire logic              pix_adv,
    input  wire logic              line_start,
    input  spo_pkg::spo_pat_e      sel,
    input  wire logic [15:0]       value,
    input  wire logic [7:0]        step,
    input  wire logic [7:0]        pitch,
    input  wire logic [7:0]        start_len,
    input  wire logic [7:0]        width,
    output logic      [15:0]       pix
);
    import spo_pkg::*;
    typedef struct packed {
        logic [7:0]  pos;
        logic [7:0]  pitch_cnt;
        logic [7:0]  line_cnt;
        logic [13:0] grad;
        logic [13:0] vgrad;
        logic        stripe;
        logic [15:0] pix;
    } spo_gen_s;
    spo_gen_s st, next_st;

    function automatic logic [13:0] spo_inc(input logic [13:0] v,
                                            input logic [7:0]  s);
        logic [14:0] sum;
        sum = {1'b0, v} + {7'h00, s};
        spo_inc = sum[14] ? 14'h0000 : sum[13:0];
    endfunction

    logic in_valid;
    logic pitch_end;
    logic lattice_on;
    always_comb begin
        next_st    = st;
        in_valid   = (st.pos >= start_len) &&
                     ({1'b0, st.pos} < ({1'b0, start_len} + {1'b0, width}));
        pitch_end  = (st.pitch_cnt + 8'h01 >= pitch);
        lattice_on = (st.pitch_cnt == 8'h00) || (st.line_cnt == 8'h00);
        if (!run) begin
            next_st = '0;
            next_st.grad  = value[13:0];
            next_st.vgrad = value[13:0];
        end else if (line_start) begin
            next_st.pos       = 8'h00;
            next_st.pitch_cnt = 8'h00;
            next_st.stripe    = 1'b0;
            next_st.grad      = value[13:0];
            next_st.line_cnt  = (st.line_cnt + 8'h01 >= pitch) ? 8'h00
                                : st.line_cnt + 8'h01;
            if (st.line_cnt + 8'h01 >= pitch)
                next_st.vgrad = spo_inc(st.vgrad, step); // RQ25
        end else if (pix_adv) begin
            if (st.pos != 8'hFF)
                next_st.pos = st.pos + 8'h01;
            if (in_valid) begin
                next_st.pitch_cnt = pitch_end ? 8'h00 : st.pitch_cnt + 8'h01;
                if (pitch_end) begin
                    next_st.grad   = spo_inc(st.grad, step); // RQ19
                    next_st.stripe = ~st.stripe;
                end
            end
            if (sel == SPO_PAT_SYNC || sel == SPO_PAT_ASYNC)
                next_st.pix = value; // RQ22 RQ24
            else if (!in_valid)
                next_st.pix = 16'h0000; // RQ14
            else begin
                case (sel)
                    SPO_PAT_FIXED:  next_st.pix = {2'b00, value[13:0]}; // RQ18
                    SPO_PAT_HGRAD:  next_st.pix = {2'b00, st.grad}; // RQ19
                    SPO_PAT_VGRAD:  next_st.pix = {2'b00, st.vgrad}; // RQ25
                    SPO_PAT_LATT:   next_st.pix = lattice_on ? // RQ20
                                    {8'h00, step} : {2'b00, value[13:0]};
                    SPO_PAT_STRIPE: next_st.pix = st.stripe ? // RQ21
                                    {8'h00, step} : {2'b00, value[13:0]};
                    default:        next_st.pix = 16'h0000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            st <= '0;
        else
            st <= next_st;
    end
    assign pix = st.pix;
endmodule

// ===== design/spo_pkg.sv
package spo_pkg;
    typedef logic [13:0] spo_pix_t;
    typedef enum logic [2:0] {
        SPO_PAT_FIXED  = 3'h0,
        SPO_PAT_HGRAD  = 3'h1,
        SPO_PAT_VGRAD  = 3'h2,
        SPO_PAT_LATT   = 3'h3,
        SPO_PAT_STRIPE = 3'h4,
        SPO_PAT_SYNC   = 3'h5,
        SPO_PAT_ASYNC  = 3'h6,
        SPO_PAT_RSVD   = 3'h7
    } spo_pat_e;
    typedef enum logic [1:0] {
        SPO_GEN_IDLE  = 2'h0,
        SPO_GEN_ARMED = 2'h1,
        SPO_GEN_RUN   = 2'h2
    } spo_gen_e;
endpackage

// ===== design/spo_serial_out.sv
`timescale 1ns/1ns
`include "spo_defines.svh"
// ==================================================
// serial pixel output with test patterns, AHB-Lite slave
// Notes on behaviour
// RQ1: 14-bit word inside a sixteen-bit slot
// RQ2: marker rises with word MSB
// RQ3: paired sampling marker: odd three, even two
// RQ4: sample-hold marker always three periods
// RQ5: dual lane, one lane, sixteen per pixel
// RQ6: dual sample-hold marker falls at bit 7
// RQ7: dual paired marker falls bit 9/bit 7
// RQ8: dual lane clock centred in data eye
// RQ9: quad lane: bits 13-7 and 6-0
// RQ10: quad marker falls bits 10/3 or 11/4
// RQ11: quad clock rising edges inside eye
// RQ12: three-bit select picks test pattern
// RQ13: pattern replaces converter data until disabled
// RQ14: zero for start pixels, then pattern
// RQ15: software sets test mode, parameters, enable
// RQ16: pattern starts at next clamp rising edge
// RQ17: software keeps parameters still while enabled
// RQ18: fixed pattern from 6+8 value bits
// RQ19: horizontal gradient with pitch and step
// RQ20: lattice lines over background
// RQ21: stripes of pitch width alternate
// RQ22: synchronous constant 16-bit from clamp edge
// RQ23: clamp input is driven from outside
// RQ24: asynchronous constant starts without clamp edge
// RQ25: vertical gradient advances per line; code advances it only once every pitch lines
// RQ26: one setting switches dual or quad
module spo_serial_out (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        link_clk,
    input  wire logic        clamp_input,
    input  wire logic        line_start,
    input  wire logic [13:0] adc_ch1,
    input  wire logic [13:0] adc_ch2,
    output logic      [3:0]  serial_data_lane,
    output logic             frame_marker_out,
    output logic             forwarded_serial_clock
);
    import spo_pkg::*;

    typedef struct packed {
        logic        ap_wr;
        logic        slot_quad;
        logic [7:0]  ap_addr;
        logic [31:0] rdata;
        logic [7:0]  pat_ctrl;
        logic [7:0]  test_scan;
        logic [7:0]  val_up;
        logic [7:0]  val_lo;
        logic [7:0]  step;
        logic [7:0]  pitch;
        logic [7:0]  start_len;
        logic [7:0]  width;
        logic [1:0]  out_cfg;
        spo_gen_e    gen;
        logic        clamp_d;
        logic        lclk_d;
        logic [3:0]  bit_idx;
        logic        odd;
        logic [13:0] sh1;
        logic [13:0] sh2;
        logic [13:0] cur1;
        logic [13:0] cur2;
        logic [3:0]  lane;
        logic        frame;
        logic        fclk;
    } spo_top_s;
    spo_top_s st, next_st;

    logic        clamp_s;
    logic        lclk_s;
    logic [15:0] pat_pix;
    logic        pix_adv;
    logic        run;
    logic        quad;
    logic        correlated_double_sampling;
    logic        lclk_rise;
    logic        lclk_fall;
    logic [3:0]  slot_end;
    logic [3:0]  fall_at;

    spo_sync #(.W(2)) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       ({clamp_input, link_clk}),
        .q       ({clamp_s, lclk_s})
    );

    spo_pattern_gen u_gen (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .run        (run),
        .pix_adv    (pix_adv),
        .line_start (line_start),
        .sel        (spo_pat_e'(st.pat_ctrl[6:4])), // RQ12
        .value      ({st.val_up, st.val_lo}),
        .step       (st.step),
        .pitch      (st.pitch),
        .start_len  (st.start_len),
        .width      (st.width),
        .pix        (pat_pix)
    );

    // serial bit position in slot; MSB sent at index 1, guard at index 0, and also at index 15 in dual lane
    function automatic logic [3:0] spo_bit_pos(input logic [3:0] idx,
                                               input logic       q);
        spo_bit_pos = q ? 4'(4'h7 - idx) : 4'(4'hE - idx);
    endfunction

    // ==================================================
    // register read decode
    function automatic logic [31:0] spo_rd(input spo_top_s s);
        case (s.ap_addr)
            `SPO_ADDR_PAT_CTRL:  spo_rd = {24'h000000, s.pat_ctrl};
            `SPO_ADDR_TEST_SCAN: spo_rd = {24'h000000, s.test_scan};
            `SPO_ADDR_VAL_UP:    spo_rd = {24'h000000, s.val_up};
            `SPO_ADDR_VAL_LO:    spo_rd = {24'h000000, s.val_lo};
            `SPO_ADDR_STEP:      spo_rd = {24'h000000, s.step};
            `SPO_ADDR_PITCH:     spo_rd = {24'h000000, s.pitch};
            `SPO_ADDR_START:     spo_rd = {24'h000000, s.start_len};
            `SPO_ADDR_WIDTH:     spo_rd = {24'h000000, s.width};
            `SPO_ADDR_OUT_CFG:   spo_rd = {30'h00000000, s.out_cfg};
            `SPO_ADDR_STATUS:    spo_rd = {28'h0000000, s.odd,
                                           s.gen == SPO_GEN_RUN,
                                           s.gen == SPO_GEN_ARMED, s.frame};
            default:             spo_rd = 32'h00000000;
        endcase
    endfunction

    // format switches only at a slot boundary, all lanes together
    assign quad      = st.slot_quad;
    assign correlated_double_sampling = st.out_cfg[`SPO_CFG_CORR];
    assign run       = (st.gen == SPO_GEN_RUN);
    assign lclk_rise = lclk_s & ~st.lclk_d;
    assign lclk_fall = ~lclk_s & st.lclk_d;
    assign slot_end  = quad ? 4'h7 : 4'hF; // RQ5 RQ9
    assign pix_adv   = lclk_rise && (st.bit_idx == slot_end);

    always_comb begin
        next_st         = st;
        next_st.clamp_d = clamp_s;
        next_st.lclk_d  = lclk_s;
        fall_at         = 4'h0;
        // ==================================================
        // AHB-Lite slave, zero wait states
        if (hready) begin
            next_st.ap_wr   = hsel && htrans[1] && hwrite;
            next_st.ap_addr = haddr[7:0];
        end
        if (st.ap_wr) begin
            case (st.ap_addr)
                `SPO_ADDR_PAT_CTRL:  next_st.pat_ctrl  = hwdata[7:0];
                `SPO_ADDR_TEST_SCAN: next_st.test_scan = hwdata[7:0];
                `SPO_ADDR_VAL_UP:    next_st.val_up    = hwdata[7:0];
                `SPO_ADDR_VAL_LO:    next_st.val_lo    = hwdata[7:0];
                `SPO_ADDR_STEP:      next_st.step      = hwdata[7:0];
                `SPO_ADDR_PITCH:     next_st.pitch     = hwdata[7:0];
                `SPO_ADDR_START:     next_st.start_len = hwdata[7:0];
                `SPO_ADDR_WIDTH:     next_st.width     = hwdata[7:0];
                `SPO_ADDR_OUT_CFG:   next_st.out_cfg   = hwdata[1:0];
                default:             next_st.out_cfg   = st.out_cfg;
            endcase
        end
        if (hready && hsel && htrans[1] && !hwrite) begin
            next_st.ap_addr = haddr[7:0];
            next_st.rdata   = spo_rd(next_st);
        end
        // ==================================================
        // pattern start control
        case (st.gen)
            SPO_GEN_IDLE: begin
                if (st.test_scan[`SPO_TS_TEST_MODE] &&
                    st.pat_ctrl[`SPO_PC_ENABLE] &&
                    st.pat_ctrl[6:4] != 3'h7) begin
                    if (spo_pat_e'(st.pat_ctrl[6:4]) == SPO_PAT_ASYNC)
                        next_st.gen = SPO_GEN_RUN; // RQ24
                    else
                        next_st.gen = SPO_GEN_ARMED;
                end
            end
            SPO_GEN_ARMED: begin
                if (clamp_s && !st.clamp_d)
                    next_st.gen = SPO_GEN_RUN; // RQ16 RQ22 RQ23
            end
            SPO_GEN_RUN: begin
                next_st.gen = SPO_GEN_RUN; // RQ13
            end
            default: next_st.gen = SPO_GEN_IDLE;
        endcase
        if (!st.test_scan[`SPO_TS_TEST_MODE] ||
            !st.pat_ctrl[`SPO_PC_ENABLE])
            next_st.gen = SPO_GEN_IDLE;
        // ==================================================
        // serialiser, one bit per link clock period
        if (lclk_rise) begin
            next_st.bit_idx = (st.bit_idx == slot_end) ? 4'h0
                              : st.bit_idx + 4'h1;
            if (st.bit_idx == slot_end) begin
                next_st.cur1 = run ? pat_pix[13:0] : adc_ch1; // RQ13
                next_st.cur2 = run ? pat_pix[13:0] : adc_ch2;
                next_st.odd  = correlated_double_sampling ? ~st.odd
                               : 1'b1; // RQ3 RQ4
                next_st.slot_quad = st.out_cfg[`SPO_CFG_QUAD]; // RQ26
            end
            if (st.bit_idx == 4'h0) begin
                next_st.sh1 = st.cur1;
                next_st.sh2 = st.cur2;
            end
        end
        // data changes on link falling edge: centred under clock rise
        if (lclk_fall) begin
            if (quad) begin
                // RQ9
                if (st.bit_idx >= 4'h1) begin
                    next_st.lane[0] = st.sh1[4'(spo_bit_pos(st.bit_idx,
                                                   1'b1) + 4'h7)];
                    next_st.lane[1] = st.sh1[spo_bit_pos(st.bit_idx, 1'b1)];
                    next_st.lane[2] = st.sh2[4'(spo_bit_pos(st.bit_idx,
                                                   1'b1) + 4'h7)];
                    next_st.lane[3] = st.sh2[spo_bit_pos(st.bit_idx, 1'b1)];
                end else
                    next_st.lane = 4'h0;
                fall_at = st.odd ? 4'h4 : 4'h3; // RQ10
            end else begin
                // RQ1 RQ5
                if (st.bit_idx >= 4'h1 &&
                    st.bit_idx <= 4'(`SPO_WORD_BITS)) begin
                    next_st.lane[0] = st.sh1[spo_bit_pos(st.bit_idx, 1'b0)];
                    next_st.lane[1] = st.sh2[spo_bit_pos(st.bit_idx, 1'b0)];
                end else
                    next_st.lane[1:0] = 2'b00;
                next_st.lane[3:2] = 2'b00;
                fall_at = st.odd ? 4'h7 : 4'h5; // RQ6 RQ7
            end
            if (st.bit_idx == 4'h1)
                next_st.frame = 1'b1; // RQ2
            else if (st.bit_idx == fall_at)
                next_st.frame = 1'b0; // RQ3 RQ4 RQ10
        end
        // RQ8 RQ11 RQ26
        next_st.fclk = lclk_s;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign hrdata                 = st.rdata;
    assign hreadyout              = 1'b1;
    assign hresp                  = 1'b0;
    assign serial_data_lane       = st.lane;
    assign frame_marker_out       = st.frame;
    assign forwarded_serial_clock = st.fclk;
endmodule

// ===== design/spo_sync.sv
`timescale 1ns/1ns
// ==================================================
// two flop synchroniser
module spo_sync #(
    parameter int W = 1
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ===== verification/spo_link_rx.sv
`timescale 1ns/1ns
// ==========
// capturing deserialiser, samples on forwarded clock rise
module spo_link_rx (
    input  wire logic        forwarded_serial_clock,
    input  wire logic [3:0]  serial_data_lane,
    input  wire logic        frame_marker_out,
    input  wire logic        quad,
    output logic      [13:0] word1,
    output logic      [13:0] word2,
    output logic      [3:0]  hi_len,
    output int               words
);
    logic [3:0][13:0] sh;
    logic [3:0][13:0] nx;
    logic [3:0]       idx = 4'h0;
    logic [3:0]       hi = 4'h0;
    logic             prv = 1'b0;
    initial words = 0;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            nx[i] = {sh[i][12:0], serial_data_lane[i]};
        end
    end
    always @(posedge forwarded_serial_clock) begin
        sh <= nx;
        prv <= frame_marker_out;
        hi <= frame_marker_out ? hi + 4'h1 : 4'h0;
        if (prv && !frame_marker_out) begin
            hi_len <= hi;
        end
        // word starts at the marker rise
        if (frame_marker_out && !prv) begin
            idx <= 4'h1;
        end else if (idx != 4'h0) begin
            idx <= idx + 4'h1;
        end
        if (idx == (quad ? 4'h6 : 4'hD)) begin
            idx <= 4'h0;
            words <= words + 1;
            word1 <= quad ? {nx[0][6:0], nx[1][6:0]} : nx[0];
            word2 <= quad ? {nx[2][6:0], nx[3][6:0]} : nx[1];
        end
    end
endmodule

// ===== verification/spo_serial_out_asserts.sv
`timescale 1ns/1ns
// ==========
// port level checks
module spo_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [3:0]  serial_data_lane,
    input wire logic        frame_marker_out,
    input wire logic        forwarded_serial_clock
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [7:0] hi_cyc;
    logic       rd_gap;
    // cycles the marker has been high, read of an unmapped word pending
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hi_cyc <= 8'h00;
            rd_gap <= 1'b0;
        end else begin
            hi_cyc <= frame_marker_out ? hi_cyc + 8'h01 : 8'h00;
            rd_gap <= hsel && htrans[1] && hready && !hwrite
                      && haddr[7:0] > 8'h5C && haddr[7:0] < 8'hD0;
        end
    end
    a_ready_high: assert property (hreadyout)
        else $error("slave inserted a wait state");
    a_resp_okay: assert property (!hresp)
        else $error("slave answered with an error");
    a_unmapped_zero: assert property (rd_gap |-> hrdata == 32'h0)
        else $error("unmapped read returned data");
    a_eye_stable: assert property (
        forwarded_serial_clock && $past(forwarded_serial_clock)
        |-> $stable(serial_data_lane))
        else $error("lane moved while clock high");
    a_change_low: assert property (
        $changed(serial_data_lane) |-> !forwarded_serial_clock)
        else $error("lane moved near clock rise");
    a_clk_high8: assert property (
        $rose(forwarded_serial_clock)
        |-> forwarded_serial_clock [*8] ##1 !forwarded_serial_clock)
        else $error("forwarded clock high time wrong");
    a_rise_low: assert property (
        $rose(frame_marker_out) |-> !forwarded_serial_clock)
        else $error("marker rise off a bit boundary");
    a_fall_low: assert property (
        $fell(frame_marker_out) |-> !forwarded_serial_clock)
        else $error("marker fall off a bit boundary");
    a_frame_len: assert property (
        $fell(frame_marker_out)
        |-> hi_cyc inside {8'h20, 8'h30, 8'h40, 8'h60})
        else $error("marker high time wrong");
endmodule

bind spo_serial_out spo_chk u_chk (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
    .hreadyout, .hresp, .serial_data_lane, .frame_marker_out,
    .forwarded_serial_clock
);

// ===== verification/spo_serial_out_tb.sv
`timescale 1ns/1ns
`include "spo_defines.svh"
// ==========
// register and link bench
module spo_serial_out_tb;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        link_clk = 1'b0, clamp_input = 1'b0, line_start = 1'b0;
    logic        hreadyout, hresp, frame_marker_out, forwarded_serial_clock;
    logic [13:0] adc_ch1 = 14'h2A5C, adc_ch2 = 14'h1333, word1, word2;
    logic [3:0]  serial_data_lane, hi_len, h0;
    logic        quad = 1'b0;
    int          words, miscompares = 0, checked = 0;

    always #5 hclk = ~hclk;
    initial #3 forever #80 link_clk = ~link_clk;

    spo_serial_out dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
        .link_clk, .clamp_input, .line_start, .adc_ch1, .adc_ch2,
        .serial_data_lane, .frame_marker_out, .forwarded_serial_clock
    );
    spo_link_rx u_rx (
        .forwarded_serial_clock, .serial_data_lane, .frame_marker_out,
        .quad, .word1, .word2, .hi_len, .words
    );

    // ==========
    // tasks
    task automatic cmp(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s %h not %h",
                     $time, what, seen, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        v = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        cmp(v, {24'h0, e}, "register");
    endtask

    task automatic wait_words(input int n);
        int t;
        t = words + n;
        while (words < t) @(posedge hclk);
    endtask

    task automatic clamp_pulse;
        clamp_input <= 1'b1;
        repeat (4) @(posedge hclk);
        clamp_input <= 1'b0;
        // synchroniser and edge detect latency
        repeat (6) @(posedge hclk);
    endtask

    task automatic conclude;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        #400000;
        miscompares++;
        conclude();
    end

    // ==========
    // tests
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(`SPO_ADDR_PAT_CTRL, `SPO_RST_BYTE);
        rchk(`SPO_ADDR_TEST_SCAN, `SPO_RST_BYTE);
        rchk(`SPO_ADDR_OUT_CFG, `SPO_RST_BYTE);
        for (int i = 0; i < 6; i++) wr(8'(8'h40 + 4 * i), 8'(17 * i + 3));
        for (int i = 0; i < 6; i++) rchk(8'(8'h40 + 4 * i), 8'(17 * i + 3));
        wr(8'h60, 8'h5A);
        rchk(8'h60, 8'h00);
        // dual lane, sample and hold then paired sampling
        wr(`SPO_ADDR_OUT_CFG, 8'h00);
        wait_words(3);
        cmp(word1, adc_ch1, "dual ch1");
        cmp(word2, adc_ch2, "dual ch2");
        cmp(hi_len, 4'h6, "dual marker");
        wr(`SPO_ADDR_OUT_CFG, 8'h02);
        wait_words(3);
        h0 = hi_len;
        wait_words(1);
        cmp(h0 + hi_len, 4'hA, "dual paired sum");
        cmp(8'(h0 * hi_len), 8'h18, "dual paired pair");
        // quad lane
        wr(`SPO_ADDR_OUT_CFG, 8'h01);
        quad = 1'b1;
        wait_words(3);
        cmp(word1, adc_ch1, "quad ch1");
        cmp(word2, adc_ch2, "quad ch2");
        cmp(hi_len, 4'h3, "quad marker");
        wr(`SPO_ADDR_OUT_CFG, 8'h03);
        wait_words(3);
        h0 = hi_len;
        wait_words(1);
        cmp(h0 + hi_len, 4'h5, "quad paired sum");
        cmp(8'(h0 * hi_len), 8'h06, "quad paired pair");
        wr(`SPO_ADDR_OUT_CFG, 8'h00);
        quad = 1'b0;
        // test patterns
        wr(`SPO_ADDR_TEST_SCAN, 8'h02);
        wr(`SPO_ADDR_VAL_UP, 8'h15);
        wr(`SPO_ADDR_VAL_LO, 8'hC3);
        wr(`SPO_ADDR_START, 8'h08);
        wr(`SPO_ADDR_WIDTH, 8'h08);
        for (int s = 0; s < 8; s++) begin
            wr(`SPO_ADDR_PAT_CTRL, 8'(s * 16 + 1));
            repeat (4) @(posedge hclk);
            xfer(1'b0, `SPO_ADDR_STATUS, 8'h00);
            cmp(v[2], s == 6, "early run");
            if (s < 6) cmp(v[1], 1'b1, "armed");
            clamp_pulse();
            xfer(1'b0, `SPO_ADDR_STATUS, 8'h00);
            cmp(v[2], s != 7, "running");
            if (s == 0) begin
                wait_words(2);
                cmp(word1, 14'h0000, "start zero");
                wait_words(10);
                cmp(word1, 14'h15C3, "fixed ch1");
                cmp(word2, 14'h15C3, "fixed ch2");
            end else if (s == 5 || s == 6) begin
                wait_words(3);
                cmp(word1, 14'h15C3, "constant");
            end
            wr(`SPO_ADDR_PAT_CTRL, 8'h00);
            repeat (4) @(posedge hclk);
            xfer(1'b0, `SPO_ADDR_STATUS, 8'h00);
            cmp(v[2], 1'b0, "stopped");
        end
        conclude();
    end
endmodule
